//--- gpc_pkg.sv
// shared constants of the change-notify port: offsets, widths, reset values
`default_nettype none
package gpc_pkg;
    localparam int unsigned PIN_COUNT = 24;
    localparam int unsigned LOW_WIDTH = 16;
    localparam int unsigned HIGH_WIDTH = 8;
    localparam int unsigned ADDR_WIDTH = 8;
    localparam int unsigned DATA_WIDTH = 32;
    localparam int unsigned SYNC_STAGES = 2;

    // register byte offsets, one aligned word each
    localparam logic [7:0] OFF_DIRECTION = 8'h00;
    localparam logic [7:0] OFF_OUTPUT_LATCH = 8'h04;
    localparam logic [7:0] OFF_OPEN_DRAIN = 8'h08;
    localparam logic [7:0] OFF_PORT_INPUT = 8'h0c;
    localparam logic [7:0] OFF_ANA1_LOW = 8'h10;
    localparam logic [7:0] OFF_ANA1_HIGH = 8'h14;
    localparam logic [7:0] OFF_ANA2_LOW = 8'h18;
    localparam logic [7:0] OFF_ANA2_HIGH = 8'h1c;
    localparam logic [7:0] OFF_IRQ_EN_ONE = 8'h20;
    localparam logic [7:0] OFF_IRQ_EN_TWO = 8'h24;
    localparam logic [7:0] OFF_PULLUP_ONE = 8'h28;
    localparam logic [7:0] OFF_PULLUP_TWO = 8'h2c;
    localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h34;

    // field positions
    localparam int unsigned CHANGE_FLAG_BIT = 0;

    // reset values
    localparam logic [23:0] RST_DIRECTION = 24'hffffff;
    localparam logic [23:0] RST_OUTPUT_LATCH = 24'h000000;
    localparam logic [23:0] RST_OPEN_DRAIN = 24'h000000;
    localparam logic [23:0] RST_ANALOG_CFG = 24'h000000;
    localparam logic [23:0] RST_IRQ_EN = 24'h000000;
    localparam logic [23:0] RST_PULLUP = 24'h000000;
    localparam logic [23:0] RST_PREV = 24'h000000;
    localparam logic RST_IRQ_STATUS = 1'b0;
    localparam logic RST_IRQ_MASK = 1'b0;
    localparam logic [31:0] RST_RDATA = 32'h00000000;
endpackage : gpc_pkg
`default_nettype wire

//--- gpc_sync.sv
// two-stage synchroniser for the pin inputs
`default_nettype none
module gpc_sync #(
    parameter int unsigned WIDTH = gpc_pkg::PIN_COUNT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // first stage feeds only the second, so metastability never reaches logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else if (ce) begin
            stage1_reg <= d;
            stage2_reg <= stage1_reg;
        end
    end

    assign q = stage2_reg;
endmodule : gpc_sync
`default_nettype wire

//--- gpc_port.sv
// gpio port with open-drain, analog selection and change notification, apb slave
// What this block does
// - a set open-drain bit makes that pin drive low only, never high.
// - an analog pin driven as output hands its driven level to the converter.
// - a cleared analog config bit makes the pin analog; it is digital only with both bits set.
// - analog config bits reset cleared, so pins start analog.
// - with two converters a pin is analog if either config bit is cleared.
// - port input reads zero for every analog pin.
// - digital pins are never offered to converter sampling.
// - an enabled input change raises the change interrupt request.
// - change detection works without the clock running, for sleep wake-up.
// - twenty-four change inputs, each selectable as an interrupt source.
// - two enable registers select which pins may raise the change interrupt.
// - two pull-up registers turn on each pin's weak pull-up.
`default_nettype none
module gpc_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [23:0] pad_in,
    output logic [23:0] pad_out,
    output logic [23:0] pad_oe_n,
    output logic [23:0] pullup_en,
    output logic [23:0] adc_enable,
    output logic [23:0] adc_level,
    output logic change_irq,
    output logic sleep_wake
);
    // register state
    logic [23:0] dir_reg;
    logic [23:0] lat_reg;
    logic [23:0] odc_reg;
    logic [23:0] ana1_reg;
    logic [23:0] ana2_reg;
    logic [23:0] cnen_reg;
    logic [23:0] cnpu_reg;
    logic [23:0] prev_reg;
    logic [23:0] adc_level_reg;
    logic status_reg;
    logic mask_reg;
    logic [31:0] prdata_reg;
    logic slverr_reg;

    // next values
    logic [23:0] dir_next;
    logic [23:0] lat_next;
    logic [23:0] odc_next;
    logic [23:0] ana1_next;
    logic [23:0] ana2_next;
    logic [23:0] cnen_next;
    logic [23:0] cnpu_next;
    logic [23:0] adc_level_next;
    logic status_next;
    logic mask_next;

    // datapath wires
    logic [23:0] pin_sync;
    logic [23:0] analog_pin;
    logic [23:0] port_read;
    logic [23:0] change_hit;
    logic [23:0] wake_hit;
    logic [31:0] rd_data;
    logic rd_err;

    // apb decode
    logic setup_phase;
    logic wr_en;
    logic sel_dir;
    logic sel_lat;
    logic sel_odc;
    logic sel_port;
    logic sel_a1l;
    logic sel_a1h;
    logic sel_a2l;
    logic sel_a2h;
    logic sel_en1;
    logic sel_en2;
    logic sel_pu1;
    logic sel_pu2;
    logic sel_stat;
    logic sel_mask;
    logic stat_clear;

    // the slave never stalls; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign setup_phase = psel & ~penable;
    assign wr_en = psel & penable & pwrite & ce;

    // address decode
    assign sel_dir = (paddr == gpc_pkg::OFF_DIRECTION);
    assign sel_lat = (paddr == gpc_pkg::OFF_OUTPUT_LATCH);
    assign sel_odc = (paddr == gpc_pkg::OFF_OPEN_DRAIN);
    assign sel_port = (paddr == gpc_pkg::OFF_PORT_INPUT);
    assign sel_a1l = (paddr == gpc_pkg::OFF_ANA1_LOW);
    assign sel_a1h = (paddr == gpc_pkg::OFF_ANA1_HIGH);
    assign sel_a2l = (paddr == gpc_pkg::OFF_ANA2_LOW);
    assign sel_a2h = (paddr == gpc_pkg::OFF_ANA2_HIGH);
    assign sel_en1 = (paddr == gpc_pkg::OFF_IRQ_EN_ONE);
    assign sel_en2 = (paddr == gpc_pkg::OFF_IRQ_EN_TWO);
    assign sel_pu1 = (paddr == gpc_pkg::OFF_PULLUP_ONE);
    assign sel_pu2 = (paddr == gpc_pkg::OFF_PULLUP_TWO);
    assign sel_stat = (paddr == gpc_pkg::OFF_IRQ_STATUS);
    assign sel_mask = (paddr == gpc_pkg::OFF_IRQ_MASK);

    // full-width registers take the low 24 data bits, the mask takes bit 0
    assign dir_next = (wr_en & sel_dir) ? pwdata[23:0] : dir_reg;
    assign lat_next = (wr_en & sel_lat) ? pwdata[23:0] : lat_reg;
    assign odc_next = (wr_en & sel_odc) ? pwdata[23:0] : odc_reg;
    assign mask_next = (wr_en & sel_mask) ? pwdata[gpc_pkg::CHANGE_FLAG_BIT] : mask_reg;

    // split registers: the low word covers pins 0-15, the high word pins 16-23
    assign ana1_next = {(wr_en & sel_a1h) ? pwdata[7:0] : ana1_reg[23:16],
                        (wr_en & sel_a1l) ? pwdata[15:0] : ana1_reg[15:0]};
    assign ana2_next = {(wr_en & sel_a2h) ? pwdata[7:0] : ana2_reg[23:16],
                        (wr_en & sel_a2l) ? pwdata[15:0] : ana2_reg[15:0]};
    assign cnen_next = {(wr_en & sel_en2) ? pwdata[7:0] : cnen_reg[23:16],
                        (wr_en & sel_en1) ? pwdata[15:0] : cnen_reg[15:0]};
    assign cnpu_next = {(wr_en & sel_pu2) ? pwdata[7:0] : cnpu_reg[23:16],
                        (wr_en & sel_pu1) ? pwdata[15:0] : cnpu_reg[15:0]};

    // register file; ce low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_reg <= gpc_pkg::RST_DIRECTION;
            lat_reg <= gpc_pkg::RST_OUTPUT_LATCH;
            odc_reg <= gpc_pkg::RST_OPEN_DRAIN;
            ana1_reg <= gpc_pkg::RST_ANALOG_CFG;
            ana2_reg <= gpc_pkg::RST_ANALOG_CFG;
            cnen_reg <= gpc_pkg::RST_IRQ_EN;
            cnpu_reg <= gpc_pkg::RST_PULLUP;
            mask_reg <= gpc_pkg::RST_IRQ_MASK;
        end else if (ce) begin
            dir_reg <= dir_next;
            lat_reg <= lat_next;
            odc_reg <= odc_next;
            ana1_reg <= ana1_next;
            ana2_reg <= ana2_next;
            cnen_reg <= cnen_next;
            cnpu_reg <= cnpu_next;
            mask_reg <= mask_next;
        end
    end

    // pin inputs cross into the clock domain before any clocked use
    gpc_sync #(
        .WIDTH(gpc_pkg::PIN_COUNT)
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .d(pad_in),
        .q(pin_sync)
    );

    // analog selection: either converter's cleared bit claims the pin
    assign analog_pin = ~(ana1_reg & ana2_reg);
    assign port_read = pin_sync & ~analog_pin;

    // pad drivers: open-drain pins release instead of driving high
    assign pad_out = lat_reg;
    assign pad_oe_n = dir_reg | (odc_reg & lat_reg);
    // pull-ups follow software; it must drop them on digital outputs itself
    assign pullup_en = cnpu_reg;

    // converter feed: digital pins are masked off entirely
    assign adc_enable = analog_pin;
    // an output-configured analog pin converts what it drives, not the pad
    assign adc_level_next = analog_pin & (dir_reg & pin_sync | ~dir_reg & lat_reg);
    assign adc_level = adc_level_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            adc_level_reg <= '0;
        end else if (ce) begin
            adc_level_reg <= adc_level_next;
        end
    end

    // clocked change compare on synchronised digital inputs
    assign change_hit = cnen_reg & ~analog_pin & (pin_sync ^ prev_reg);
    // set beats a clear landing in the same cycle
    assign stat_clear = wr_en & sel_stat & pwdata[gpc_pkg::CHANGE_FLAG_BIT];
    assign status_next = (|change_hit) | (status_reg & ~stat_clear);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= gpc_pkg::RST_PREV;
            status_reg <= gpc_pkg::RST_IRQ_STATUS;
        end else if (ce) begin
            prev_reg <= pin_sync;
            status_reg <= status_next;
        end
    end

    assign change_irq = status_reg & mask_reg;

    // clockless wake path: raw pads against the last latched value, so it still
    // fires with pclk stopped; may pulse briefly while awake during sync latency
    assign wake_hit = cnen_reg & ~analog_pin & (pad_in ^ prev_reg);
    assign sleep_wake = |wake_hit;

    // read mux; unmapped offsets answer zero with an error
    always_comb begin
        rd_data = '0;
        rd_err = 1'b0;
        case (paddr)
            gpc_pkg::OFF_DIRECTION: rd_data[23:0] = dir_reg;
            gpc_pkg::OFF_OUTPUT_LATCH: rd_data[23:0] = lat_reg;
            gpc_pkg::OFF_OPEN_DRAIN: rd_data[23:0] = odc_reg;
            gpc_pkg::OFF_PORT_INPUT: rd_data[23:0] = port_read;
            gpc_pkg::OFF_ANA1_LOW: rd_data[15:0] = ana1_reg[15:0];
            gpc_pkg::OFF_ANA1_HIGH: rd_data[7:0] = ana1_reg[23:16];
            gpc_pkg::OFF_ANA2_LOW: rd_data[15:0] = ana2_reg[15:0];
            gpc_pkg::OFF_ANA2_HIGH: rd_data[7:0] = ana2_reg[23:16];
            gpc_pkg::OFF_IRQ_EN_ONE: rd_data[15:0] = cnen_reg[15:0];
            gpc_pkg::OFF_IRQ_EN_TWO: rd_data[7:0] = cnen_reg[23:16];
            gpc_pkg::OFF_PULLUP_ONE: rd_data[15:0] = cnpu_reg[15:0];
            gpc_pkg::OFF_PULLUP_TWO: rd_data[7:0] = cnpu_reg[23:16];
            gpc_pkg::OFF_IRQ_STATUS: rd_data[0] = status_reg;
            gpc_pkg::OFF_IRQ_MASK: rd_data[0] = mask_reg;
            default: rd_err = 1'b1;
        endcase
    end

    // capture at setup so prdata is a flop yet the access needs no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= gpc_pkg::RST_RDATA;
            slverr_reg <= 1'b0;
        end else if (ce && setup_phase) begin
            prdata_reg <= pwrite ? gpc_pkg::RST_RDATA : rd_data;
            slverr_reg <= rd_err;
        end
    end

    assign prdata = prdata_reg;
    assign pslverr = slverr_reg & psel & penable;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence port_read_s;
        ce && setup_phase && !pwrite && sel_port;
    endsequence

    sequence change_seen_s;
        ce && (|change_hit);
    endsequence

    sequence two_ce_s;
        ce ##1 ce;
    endsequence

    // a one written to the flag with no fresh change landing in the same cycle
    sequence flag_clear_s;
        ce && stat_clear && !(|change_hit);
    endsequence

    open_drain_a: assert property (
        (|(odc_reg & lat_reg)) |-> ((pad_oe_n & odc_reg & lat_reg) == (odc_reg & lat_reg))
    ) else $error("open-drain pin drives high");

    analog_read_a: assert property (
        port_read_s |=> ((prdata[23:0] & $past(analog_pin)) == 24'h000000)
    ) else $error("analog pin reads nonzero");

    reset_analog_a: assert property (
        ($past(presetn) == 1'b0) |-> (analog_pin == 24'hffffff)
    ) else $error("pins not analog after reset");

    either_conv_a: assert property (
        (ce && $past(ce)) |-> ((adc_level_reg & ~$past(~(ana1_reg & ana2_reg))) == 24'h000000)
    ) else $error("converter level on pin no converter claims");

    driven_level_a: assert property (
        (ce && (|(analog_pin & ~dir_reg))) |=>
            ((adc_level_reg & $past(analog_pin & ~dir_reg)) == $past(lat_reg & analog_pin & ~dir_reg))
    ) else $error("converter not fed the driven level");

    change_flag_a: assert property (
        change_seen_s |=> status_reg
    ) else $error("change not flagged");

    no_enable_a: assert property (
        (ce && !status_reg && (cnen_reg == 24'h000000)) |=> !status_reg
    ) else $error("flag set with no enabled pin");

    irq_out_a: assert property (
        change_seen_s ##1 mask_reg |-> change_irq
    ) else $error("change irq not raised");

    sync_delay_a: assert property (
        two_ce_s |=> (pin_sync == $past(pad_in, 2))
    ) else $error("synchroniser latency wrong");

    wake_path_a: assert property (
        (|(cnen_reg & ~analog_pin & (pad_in ^ prev_reg))) |-> sleep_wake
    ) else $error("wake not raised on pin change");

    pullup_a: assert property (
        (ce && psel && penable && pwrite && sel_pu2) |=> (pullup_en[23:16] == $past(pwdata[7:0]))
    ) else $error("pull-up write not applied");

    // write-one-to-clear must really drop the flag when nothing new arrives
    clear_flag_a: assert property (
        flag_clear_s |=> !status_reg
    ) else $error("change flag not cleared");

    // analog or disabled pins alone must never raise the shared flag
    quiet_pins_a: assert property (
        (ce && !status_reg && ((cnen_reg & ~analog_pin) == 24'h000000)) |=> !status_reg
    ) else $error("flag set by analog or disabled pin");

    // an input-configured analog pin hands the converter its synchronised level
    input_level_a: assert property (
        (ce && (|(analog_pin & dir_reg))) |=>
            ((adc_level_reg & $past(analog_pin & dir_reg))
                == $past(pin_sync & analog_pin & dir_reg))
    ) else $error("converter not fed the pin level");

    // with ce low the wake reference must not move, or a change could be lost
    frozen_state_a: assert property (
        !ce |=> ($stable(status_reg) && $stable(pin_sync) && $stable(prev_reg))
    ) else $error("state moved with ce low");

    // no enabled digital pin means no wake request at all
    wake_quiet_a: assert property (
        ((cnen_reg & ~analog_pin) == 24'h000000) |-> !sleep_wake
    ) else $error("wake raised with no enabled digital pin");

    // every pad starts released and the converter sees nothing
    reset_inputs_a: assert property (
        ($past(presetn) == 1'b0) |-> ((pad_oe_n == 24'hffffff) && (adc_level == 24'h000000))
    ) else $error("pins not inputs after reset");
endmodule : gpc_port
`default_nettype wire

//--- gpc_port_end_marker_unused.sv
// intentionally empty compilation unit
`default_nettype none
`default_nettype wire

//--- gpc_pin_model.sv
// far-side pin model: external drivers, weak pull-ups, floating pins
`default_nettype none
module gpc_pin_model (
    input wire logic pclk,
    input wire logic [23:0] pad_out,
    input wire logic [23:0] pad_oe_n,
    input wire logic [23:0] pullup_en,
    input wire logic [23:0] ext_en,
    input wire logic [23:0] ext_val,
    output logic [23:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [23:0] last_reg = 24'h000000;
    logic [23:0] free;
    // an open-drain pin at high is released, so the outside decides it
    assign free = pad_oe_n;
    // outside drive wins, then the pull-up; an undriven pin wanders
    assign pad_in = (~free & pad_out) | (free & ext_en & ext_val)
        | (free & ~ext_en & pullup_en)
        | (free & ~ext_en & ~pullup_en & ~last_reg);
    // history keeps a floating pin from holding a stale level
    always_ff @(posedge pclk) begin
        last_reg <= pad_in;
    end
endmodule : gpc_pin_model
`default_nettype wire

//--- tb_gpio_port_change_notify.sv
// self-checking bench of the change-notify gpio port
`default_nettype none
module tb_gpio_port_change_notify;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd, lat, od;
    logic pready, pslverr, change_irq, sleep_wake, err;
    logic [23:0] pad_in, pad_out, pad_oe_n, pullup_en, adc_enable, adc_level;
    logic [23:0] ext_en = 24'hffffff;
    logic [23:0] ext_val = 24'h000000;
    logic [31:0] c [4];
    int fail_count = 0;
    int n_tests = 0;

    // 10 MHz bus clock
    always #50 pclk = ~pclk;

    gpc_port gpc_port_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_en(pullup_en),
        .adc_enable(adc_enable), .adc_level(adc_level), .change_irq(change_irq),
        .sleep_wake(sleep_wake));
    gpc_pin_model gpc_pin_model_i (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_word

    // one apb transfer; waits for pready, takes read data at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        if (n >= 20) begin
            fail_count++;
            $display("Error at %0t: no pready on the bus", $time);
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // both converters' config words to all-digital
    task automatic set_digital();
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, gpc_pkg::OFF_ANA1_LOW + 8'(4 * i), 32'h0000ffff);
        end
    endtask : set_digital

    // a pin is analog when either converter has its bit cleared
    function automatic logic [31:0] exp_ana(input logic [31:0] w [4]);
        return {8'h00, ~{w[1][7:0], w[0][15:0]} | ~{w[3][7:0], w[2][15:0]}};
    endfunction : exp_ana

    // pin level: driven latch value, or outside level where released
    function automatic logic [31:0] exp_pad(input logic [23:0] l, input logic [23:0] o);
        logic [23:0] f;
        f = o & l;
        return {8'h00, (~f & l) | (f & ext_val)};
    endfunction : exp_pad

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // watchdog, several times the expected run length
    initial begin
        repeat (8000) @(posedge pclk);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict();
    end

    initial begin
        void'($urandom(53128));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of every word, plus one unmapped word at the end
        for (int k = 0; k < 15; k++) begin
            apb(1'b0, 8'(k * 4), 32'h0);
            check_word(rd, (k == 0) ? 32'h00ffffff : 32'h0);
            check_word({31'h0, err}, {31'h0, k == 14});
        end
        check_word({8'h00, adc_enable}, 32'h00ffffff);
        check_word({8'h00, pad_oe_n}, 32'h00ffffff);
        // all outputs with a random open-drain mix
        lat = $urandom() & 32'h00ffffff;
        od = $urandom() & 32'h00ffffff;
        ext_val <= 24'($urandom());
        apb(1'b1, gpc_pkg::OFF_DIRECTION, 32'h0);
        apb(1'b1, gpc_pkg::OFF_OUTPUT_LATCH, lat);
        apb(1'b1, gpc_pkg::OFF_OPEN_DRAIN, od);
        set_digital();
        repeat (4) @(posedge pclk);
        check_word({8'h00, pad_oe_n}, od & lat);
        check_word({8'h00, pad_out}, lat);
        check_word({8'h00, adc_enable}, 32'h0);
        check_word({8'h00, adc_level}, 32'h0);
        apb(1'b0, gpc_pkg::OFF_PORT_INPUT, 32'h0);
        check_word(rd, exp_pad(lat[23:0], od[23:0]));
        // analog selection from two converters; first pass only converter two
        for (int t = 0; t < 6; t++) begin
            foreach (c[i]) c[i] = $urandom() & 32'h0000ffff;
            if (t == 0) begin
                c = '{32'h0000ffff, 32'h000000ff, 32'h00000000, 32'h00000000};
            end
            foreach (c[i]) apb(1'b1, gpc_pkg::OFF_ANA1_LOW + 8'(4 * i), c[i]);
            repeat (4) @(posedge pclk);
            check_word({8'h00, adc_enable}, exp_ana(c));
            check_word({8'h00, adc_level}, exp_ana(c) & lat);
            apb(1'b0, gpc_pkg::OFF_PORT_INPUT, 32'h0);
            check_word(rd, exp_pad(lat[23:0], od[23:0]) & ~exp_ana(c));
        end
        // pins back to inputs before any pull-up goes on
        apb(1'b1, gpc_pkg::OFF_DIRECTION, 32'h00ffffff);
        set_digital();
        c[0] = $urandom();
        c[1] = $urandom();
        apb(1'b1, gpc_pkg::OFF_PULLUP_ONE, c[0]);
        apb(1'b1, gpc_pkg::OFF_PULLUP_TWO, c[1]);
        @(posedge pclk);
        check_word({8'h00, pullup_en}, {8'h00, c[1][7:0], c[0][15:0]});
        apb(1'b0, gpc_pkg::OFF_PULLUP_TWO, 32'h0);
        check_word(rd, {24'h0, c[1][7:0]});
        // every change input alone: a disabled neighbour is ignored
        apb(1'b1, gpc_pkg::OFF_IRQ_MASK, 32'h1);
        for (int p = 0; p < 24; p++) begin
            apb(1'b1, gpc_pkg::OFF_IRQ_EN_ONE, (p < 16) ? (32'h1 << p) : 32'h0);
            apb(1'b1, gpc_pkg::OFF_IRQ_EN_TWO, (p < 16) ? 32'h0 : (32'h1 << (p - 16)));
            repeat (5) @(posedge pclk);
            apb(1'b1, gpc_pkg::OFF_IRQ_STATUS, 32'h1);
            ext_val[(p + 1) % 24] <= ~ext_val[(p + 1) % 24];
            repeat (5) @(posedge pclk);
            apb(1'b0, gpc_pkg::OFF_IRQ_STATUS, 32'h0);
            check_word(rd, 32'h0);
            ext_val[p] <= ~ext_val[p];
            repeat (5) @(posedge pclk);
            check_word({31'h0, change_irq}, 32'h1);
            apb(1'b0, gpc_pkg::OFF_IRQ_STATUS, 32'h0);
            check_word(rd, 32'h1);
            apb(1'b1, gpc_pkg::OFF_IRQ_STATUS, 32'h1);
            @(posedge pclk);
            check_word({31'h0, change_irq}, 32'h0);
        end
        // masked change still latches the flag but holds the request low
        apb(1'b1, gpc_pkg::OFF_IRQ_MASK, 32'h0);
        ext_val[23] <= ~ext_val[23];
        repeat (5) @(posedge pclk);
        check_word({31'h0, change_irq}, 32'h0);
        apb(1'b0, gpc_pkg::OFF_IRQ_STATUS, 32'h0);
        check_word(rd, 32'h1);
        // clock frozen: the wake path must still see the change
        ce <= 1'b0;
        ext_val[23] <= ~ext_val[23];
        // stay frozen a few cycles: the request must hold with no clocked logic moving
        repeat (3) @(posedge pclk);
        check_word({31'h0, sleep_wake}, 32'h1);
        ce <= 1'b1;
        give_verdict();
    end
endmodule : tb_gpio_port_change_notify
`default_nettype wire
